/* adc_post_processing.sv */
// Realignment and cascaded 2x decimation after the converter core
`timescale 1ns/1ps
`include "post_proc_cfg.svh"
module adc_post_processing
	import post_proc_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int STAGES = `PP_MAX_STAGES,
	parameter bit HAS_EXTRA_LSB = 1'b1,
	parameter int LAT = `PP_REALIGN_LAT
)
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [DATA_W-1:0] core_data,
	input wire logic [2:0] core_chan,
	input wire logic core_valid,
	output logic [DATA_W+1:0] out_a,
	output logic [DATA_W+1:0] out_b,
	output logic out_valid,
	output logic extra_lsb_active
);
	localparam int ACC_W = DATA_W + 12;
	typedef struct packed {
		logic [7:0] rdata;
		logic [7:0] out_rate;
		logic extra_lsb_enable;
		logic dual_path_enable;
		logic realign_enable;
		logic [8:0] chain_a_stage_enables;
		logic [7:0] chain_b_stage_enables;
		logic realign_band_select;
		logic realign_variant_select;
		logic octal_path_select;
		logic continuous_wave_summing;
		logic down_conversion;
		logic single_mode;
		logic [DATA_W-1:0] prev;
		logic [DATA_W-1:0] held_a;
		logic [DATA_W+2:0] cw_sum;
		logic [DATA_W-1:0] in_a;
		logic [DATA_W-1:0] in_b;
		logic in_v;
		logic [LAT-1:0][DATA_W-1:0] dl_a;
		logic [LAT-1:0][DATA_W-1:0] dl_b;
		logic [LAT-1:0] dl_v;
		logic [STAGES-1:0][ACC_W-1:0] acc_a;
		logic [STAGES-1:0][ACC_W-1:0] acc_b;
		logic [STAGES-1:0] phase;
		logic [DATA_W+1:0] oa;
		logic [DATA_W+1:0] ob;
		logic ov;
	} state_t;
	state_t s_r, s_nxt;
	chan_mode_t mode;
	logic realign_on;
	logic [3:0] n_stages;
	logic [DATA_W-1:0] interp;
	logic [DATA_W-1:0] ra, rb;
	logic rv;
	logic [ACC_W-1:0] va, vb;
	logic vv;
	logic [ACC_W-1:0] xa, xb;
	always_comb
	begin
		if (s_r.octal_path_select)
			mode = MODE_OCTAL;
		else if (s_r.single_mode)
			mode = MODE_SINGLE;
		else
			mode = MODE_DUAL;
	end
	// Realignment only legal when the selected filter matches the path
	assign realign_on = s_r.realign_enable && (mode != MODE_SINGLE) &&
		((mode == MODE_DUAL && !s_r.realign_variant_select &&
		s_r.dual_path_enable) ||
		(mode == MODE_OCTAL && s_r.realign_variant_select &&
		!s_r.realign_band_select));
	always_comb
	begin
		n_stages = 4'h0;
		for (int i = 0; i < STAGES; i++)
			if (s_r.chain_a_stage_enables[i])
				n_stages = n_stages + 4'h1;
	end
	// Half-sample interpolation between neighbour samples of one channel
	// In the high band the neighbour term is inverted to follow aliasing
	always_comb
	begin
		if (s_r.realign_band_select)
			interp = DATA_W'((({s_r.prev[DATA_W-1], s_r.prev} -
				{s_r.in_a[DATA_W-1], s_r.in_a}) >>> 1));
		else
			interp = DATA_W'((({s_r.prev[DATA_W-1], s_r.prev} +
				{s_r.in_a[DATA_W-1], s_r.in_a}) >>> 1));
	end
	always_comb
	begin
		if (realign_on)
		begin
			ra = s_r.dl_a[LAT-1];
			rb = s_r.dl_b[LAT-1];
			rv = s_r.dl_v[LAT-1];
		end
		else
		begin
			ra = s_r.in_a;
			rb = s_r.in_b;
			rv = s_r.in_v;
		end
	end
	assign xa = ACC_W'($signed(ra));
	assign xb = ACC_W'($signed(rb));
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rdata = 8'h00;
		s_nxt.in_v = 1'b0;
		if (reg_wr)
		begin
			unique case (reg_addr)
				`PP_ADDR_OUT_RATE: s_nxt.out_rate = reg_wdata;
				`PP_ADDR_EXTRA_LSB: s_nxt.extra_lsb_enable =
					reg_wdata[`PP_BIT_EXTRA_LSB] & HAS_EXTRA_LSB;
				`PP_ADDR_DUAL_EN: s_nxt.dual_path_enable =
					reg_wdata[`PP_BIT_DUAL_EN];
				`PP_ADDR_CHAIN_A_LO:
				begin
					s_nxt.chain_a_stage_enables[0] =
						reg_wdata[`PP_BIT_CHAIN_A0];
					s_nxt.realign_enable = reg_wdata[`PP_BIT_REALIGN_EN];
				end
				`PP_ADDR_CHAIN_A_HI: s_nxt.chain_a_stage_enables[8:1] = reg_wdata;
				`PP_ADDR_CHAIN_B: s_nxt.chain_b_stage_enables = reg_wdata;
				`PP_ADDR_VARIANT:
				begin
					s_nxt.realign_band_select = reg_wdata[`PP_BIT_BAND];
					s_nxt.realign_variant_select = reg_wdata[`PP_BIT_VARIANT];
					s_nxt.octal_path_select = reg_wdata[`PP_BIT_OCTAL];
					s_nxt.continuous_wave_summing = reg_wdata[`PP_BIT_CW];
					s_nxt.down_conversion = reg_wdata[`PP_BIT_CONV];
					s_nxt.single_mode = reg_wdata[`PP_BIT_SINGLE];
				end
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				`PP_ADDR_OUT_RATE: s_nxt.rdata = s_r.out_rate;
				`PP_ADDR_EXTRA_LSB: s_nxt.rdata = {7'h00, s_r.extra_lsb_enable};
				`PP_ADDR_DUAL_EN: s_nxt.rdata = {7'h00, s_r.dual_path_enable};
				`PP_ADDR_CHAIN_A_LO: s_nxt.rdata = {s_r.realign_enable, 6'h00,
					s_r.chain_a_stage_enables[0]};
				`PP_ADDR_CHAIN_A_HI: s_nxt.rdata = s_r.chain_a_stage_enables[8:1];
				`PP_ADDR_CHAIN_B: s_nxt.rdata = s_r.chain_b_stage_enables;
				`PP_ADDR_VARIANT: s_nxt.rdata = {2'h0, s_r.single_mode,
					s_r.down_conversion, s_r.continuous_wave_summing,
					s_r.octal_path_select, s_r.realign_variant_select,
					s_r.realign_band_select};
				`PP_ADDR_STATUS: s_nxt.rdata = {3'h0, realign_on, n_stages};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		// Input capture: channel 0 goes to A, channel 1 to B (any nonzero channel in octal mode without CW summing); single mode puts every sample in A
		if (core_valid)
		begin
			if (mode == MODE_OCTAL && s_r.continuous_wave_summing)
			begin
				if (core_chan == 3'h0)
					s_nxt.cw_sum = (DATA_W+3)'($signed(core_data));
				else
					s_nxt.cw_sum = s_r.cw_sum +
						(DATA_W+3)'($signed(core_data));
				if (core_chan == 3'h7)
				begin
					// Sum scaled by eight so the word keeps its width
					s_nxt.in_a = DATA_W'((s_r.cw_sum +
						(DATA_W+3)'($signed(core_data))) >>> 3);
					s_nxt.in_b = '0;
					s_nxt.in_v = 1'b1;
				end
			end
			else if (mode == MODE_SINGLE)
			begin
				s_nxt.in_a = core_data;
				s_nxt.in_b = '0;
				s_nxt.in_v = 1'b1;
			end
			else if (core_chan == 3'h0)
				s_nxt.held_a = core_data;
			else if (core_chan == 3'h1 || mode == MODE_OCTAL)
			begin
				s_nxt.in_a = s_r.held_a;
				s_nxt.in_b = core_data;
				s_nxt.in_v = 1'b1;
			end
		end
		// Fixed delay line keeps the realigned path exactly LAT long
		s_nxt.dl_a[0] = interp;
		s_nxt.dl_b[0] = s_r.in_b;
		s_nxt.dl_v[0] = s_r.in_v;
		if (s_r.in_v)
			s_nxt.prev = s_r.in_a;
		for (int i = 1; i < LAT; i++)
		begin
			s_nxt.dl_a[i] = s_r.dl_a[i-1];
			s_nxt.dl_b[i] = s_r.dl_b[i-1];
			s_nxt.dl_v[i] = s_r.dl_v[i-1];
		end
		// Decimation: each enabled stage that is not skipped averages two words, halving rate
		va = xa;
		vb = xb;
		vv = rv;
		for (int i = 0; i < STAGES; i++)
		begin
			// Stage 0 and stage STAGES-1 are skipped whenever the mode is not single
			if (s_r.chain_a_stage_enables[i] && !(mode != MODE_SINGLE &&
				(i == 0 || i == STAGES-1)))
			begin
				if (vv)
				begin
					if (!s_r.phase[i])
					begin
						s_nxt.acc_a[i] = va;
						s_nxt.acc_b[i] = vb;
					end
					s_nxt.phase[i] = !s_r.phase[i];
					vv = s_r.phase[i];
					va = ACC_W'(($signed(s_r.acc_a[i]) + $signed(va)) >>> 1);
					vb = ACC_W'(($signed(s_r.acc_b[i]) + $signed(vb)) >>> 1);
				end
			end
			else
				s_nxt.phase[i] = 1'b0;
		end
		s_nxt.ov = vv;
		if (vv)
		begin
			// Extra LSBs are zero fill here; the bit dropped by the averaging is lost
			s_nxt.oa = s_r.extra_lsb_enable ? {va[DATA_W-1:0], 2'h0} :
				(DATA_W+2)'($signed(va[DATA_W-1:0]));
			if (mode == MODE_SINGLE && !s_r.down_conversion)
				s_nxt.ob = '0;
			else
				s_nxt.ob = s_r.extra_lsb_enable ? {vb[DATA_W-1:0], 2'h0} :
					(DATA_W+2)'($signed(vb[DATA_W-1:0]));
		end
	end
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	assign reg_rdata = s_r.rdata;
	assign out_a = s_r.oa;
	assign out_b = s_r.ob;
	assign out_valid = s_r.ov;
	assign extra_lsb_active = s_r.extra_lsb_enable;
endmodule

/* post_proc_cfg.svh */
// Constants for the post-processing path
`ifndef POST_PROC_CFG_SVH
`define POST_PROC_CFG_SVH
`define PP_ADDR_OUT_RATE 8'h02
`define PP_ADDR_EXTRA_LSB 8'h68
`define PP_ADDR_DUAL_EN 8'h79
`define PP_ADDR_CHAIN_A_LO 8'h7a
`define PP_ADDR_CHAIN_A_HI 8'h7b
`define PP_ADDR_CHAIN_B 8'h7c
`define PP_ADDR_VARIANT 8'h81
`define PP_ADDR_STATUS 8'hd0
`define PP_BIT_DUAL_EN 0
`define PP_BIT_CHAIN_A0 0
`define PP_BIT_REALIGN_EN 7
`define PP_BIT_EXTRA_LSB 0
`define PP_BIT_BAND 0
`define PP_BIT_VARIANT 1
`define PP_BIT_OCTAL 2
`define PP_BIT_CW 3
`define PP_BIT_CONV 4
`define PP_BIT_SINGLE 5
`define PP_REALIGN_LAT 59
`define PP_MAX_STAGES 9
`define PP_MAX_STAGES_DUAL 8
`endif

/* post_proc_pkg.sv */
// Types for the post-processing path
package post_proc_pkg;
	typedef enum logic [2:0] {
		MODE_SINGLE = 3'b001,
		MODE_DUAL = 3'b010,
		MODE_OCTAL = 3'b100
	} chan_mode_t;
endpackage

/* pp_core_model.sv */
// Converter core stand-in: bursts of equal samples
`timescale 1ns/1ps
module pp_core_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic [3:0] n,
	input wire logic [3:0] nch,
	input wire logic [15:0] d,
	output logic [15:0] core_data,
	output logic [2:0] core_chan,
	output logic core_valid,
	output logic busy
);
	logic [5:0] k = 6'h00;
	logic [2:0] c = 3'h0;
	initial core_data = 16'h0000;
	initial core_chan = 3'h0;
	initial core_valid = 1'b0;
	assign busy = k != 6'h00;
	// Idle lines toggle so a stale sample is never mistaken for a new one
	always @(posedge mclk)
	begin
		core_valid <= 1'b0;
		core_data <= ~core_data;
		core_chan <= ~core_chan;
		if (go)
		begin
			k <= {n, 2'b00};
			c <= 3'h0;
		end
		else if (busy)
		begin
			k <= k - 6'h01;
			if (k[1:0] == 2'h1)
			begin
				core_valid <= 1'b1;
				core_data <= d;
				core_chan <= c;
				c <= ({1'b0, c} + 4'h1 == nch) ? 3'h0 : c + 3'h1;
			end
		end
	end
endmodule

/* adc_post_processing_assertions.sv */
// Port-level checks for the post-processing path
`timescale 1ns/1ps
module adc_post_processing_chk #(
	parameter int DATA_W = 16,
	parameter bit HAS_EXTRA_LSB = 1'b1,
	parameter int LAT = 59
)
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [DATA_W-1:0] core_data,
	input wire logic [2:0] core_chan,
	input wire logic core_valid,
	input wire logic [DATA_W+1:0] out_a,
	input wire logic [DATA_W+1:0] out_b,
	input wire logic out_valid,
	input wire logic extra_lsb_active
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_rd; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_rd: assert property (p_rd) else $error("stray read data");
	property p_cause; out_valid |-> $past(core_valid, 2) ||
		$past(core_valid, LAT + 2); endproperty
	a_cause: assert property (p_cause) else $error("bad latency");
	property p_hold_a; !out_valid |-> $stable(out_a); endproperty
	a_hold_a: assert property (p_hold_a) else $error("out_a moved");
	property p_hold_b; !out_valid |-> $stable(out_b); endproperty
	a_hold_b: assert property (p_hold_b) else $error("out_b moved");
	property p_lsb; out_valid && extra_lsb_active |->
		out_a[1:0] == 2'b00 && out_b[1:0] == 2'b00; endproperty
	a_lsb: assert property (p_lsb) else $error("low bits set");
	property p_sext; out_valid && !extra_lsb_active |->
		out_a[DATA_W+1:DATA_W-1] inside {3'b000, 3'b111}; endproperty
	a_sext: assert property (p_sext) else $error("not extended");
	property p_chg; $changed(extra_lsb_active) |->
		$past(reg_wr) || $past(reg_wr, 2); endproperty
	a_chg: assert property (p_chg) else $error("mode moved");
	property p_cap; extra_lsb_active |-> HAS_EXTRA_LSB; endproperty
	a_cap: assert property (p_cap) else $error("no extension");
	c_out: cover property (out_valid);
	c_x: cover property (out_valid && extra_lsb_active);
	c_rd: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind adc_post_processing adc_post_processing_chk #(.DATA_W(DATA_W),
	.HAS_EXTRA_LSB(HAS_EXTRA_LSB), .LAT(LAT)) chk_i (.mclk(mclk),
	.rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.core_data(core_data), .core_chan(core_chan), .core_valid(core_valid),
	.out_a(out_a), .out_b(out_b), .out_valid(out_valid),
	.extra_lsb_active(extra_lsb_active));

/* tb.sv */
// Self-checking bench for the post-processing path
`timescale 1ns/1ps
module tb;
	import post_proc_pkg::*;
	localparam int LAT = 4;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [15:0] core_data;
	logic [2:0] core_chan;
	logic core_valid;
	logic [17:0] out_a;
	logic [17:0] out_b;
	logic out_valid;
	logic extra_lsb_active;
	logic go = 1'b0;
	logic [3:0] n = 4'h0;
	logic [3:0] nch = 4'h1;
	logic [15:0] d = 16'h0000;
	logic busy;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	int tin = 0;
	int tout = 0;
	int nv = 0;
	int nv0 = 0;
	logic [17:0] va;
	logic [17:0] vb;
	always #5 mclk = ~mclk;
	adc_post_processing #(.LAT(LAT)) dut (.mclk(mclk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_data(core_data),
		.core_chan(core_chan), .core_valid(core_valid), .out_a(out_a),
		.out_b(out_b), .out_valid(out_valid),
		.extra_lsb_active(extra_lsb_active));
	pp_core_model core (.mclk(mclk), .go(go), .n(n), .nch(nch), .d(d),
		.core_data(core_data), .core_chan(core_chan),
		.core_valid(core_valid), .busy(busy));
	always @(posedge mclk)
	begin
		cyc++;
		if (core_valid)
			tin = cyc;
		if (out_valid === 1'b1)
		begin
			tout = cyc;
			nv++;
			va = out_a;
			vb = out_b;
		end
	end
	task automatic end_sim;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [17:0] s, input logic [17:0] e);
		n_checks++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// One idle edge so the next call never reassigns the strobe
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		// Read data stands only in this cycle; look away from the edge
		@(negedge mclk);
		chk({10'h000, reg_rdata}, {10'h000, e});
		@(posedge mclk);
	endtask
	// Drains for the fixed pipeline depth after the last sample
	task automatic burst(input logic [3:0] k, input logic [3:0] c,
		input logic [15:0] v);
		int i;
		nv0 = nv;
		n <= k;
		nch <= c;
		d <= v;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		for (i = 0; i < 80 && busy; i++)
			@(posedge mclk);
		if (i == 80)
		begin
			fails++;
			end_sim();
		end
		repeat (LAT + 6) @(posedge mclk);
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd(8'h81, 8'h00);
		rd(8'h10, 8'h00);
		wr(8'h02, 8'h33);
		rd(8'h02, 8'h33);
		wr(8'h81, 8'h20);
		wr(8'h7a, 8'h80);
		rd(8'hd0, 8'h00);
		burst(4'h1, 4'h1, 16'h9234);
		chk(18'(tout - tin), 18'd2);
		chk(va, 18'h39234);
		chk(vb, 18'h00000);
		wr(8'h7a, 8'h01);
		wr(8'h7b, 8'h03);
		rd(8'hd0, 8'h03);
		burst(4'h8, 4'h1, 16'h8001);
		chk(18'(nv - nv0), 18'd1);
		chk(va, 18'h38001);
		wr(8'h68, 8'h01);
		burst(4'h8, 4'h1, 16'h0005);
		chk(va, 18'h00014);
		chk({17'h0, extra_lsb_active}, 18'h1);
		wr(8'h68, 8'h00);
		wr(8'h7b, 8'h00);
		wr(8'h7a, 8'h80);
		wr(8'h81, 8'h00);
		wr(8'h79, 8'h01);
		rd(8'hd0, 8'h10);
		burst(4'h2, 4'h2, 16'h0100);
		chk(18'(tout - tin), 18'(LAT + 2));
		wr(8'h81, 8'h02);
		rd(8'hd0, 8'h00);
		wr(8'h81, 8'h06);
		rd(8'hd0, 8'h10);
		wr(8'h81, 8'h07);
		rd(8'hd0, 8'h00);
		wr(8'h7a, 8'h00);
		wr(8'h7b, 8'h01);
		wr(8'h81, 8'h00);
		burst(4'h4, 4'h2, 16'h0040);
		chk(18'(nv - nv0), 18'd1);
		chk(vb, 18'h00040);
		wr(8'h7b, 8'h80);
		burst(4'h2, 4'h2, 16'h0010);
		chk(18'(nv - nv0), 18'd1);
		wr(8'h7b, 8'h00);
		wr(8'h81, 8'h0c);
		burst(4'h8, 4'h8, 16'h0020);
		chk(18'(nv - nv0), 18'd1);
		chk(va, 18'h00020);
		end_sim();
	end
endmodule
